// >>> rtl/deep_pkg.sv
package deep_pkg;
  // ---------------------------------------------------------------
  // register map
  // ---------------------------------------------------------------
  localparam logic [15:0] CTRL_STATUS_ADDR = 16'h0030;
  localparam logic [7:0] CTRL_STATUS_RST = 8'h00;
  localparam int PROGRAM_BIT = 0;
  localparam int LATCH_BIT = 1;
  // ---------------------------------------------------------------
  // eeprom window and latches
  // ---------------------------------------------------------------
  localparam logic [15:0] EE_BASE = 16'h1000;
  localparam int EE_ADDR_W = 7;
  localparam int EE_DEPTH = 128;
  localparam int LATCH_N = 32;
  localparam int COL_W = 5;
  localparam int ROW_W = 2;
  localparam logic [7:0] ERASED_BYTE = 8'hff;
  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int PROG_TIME_US = 5000;
  localparam int PROG_CYCLES = PROG_TIME_US * CLK_MHZ;
  localparam int CNT_W = 20;
endpackage

// >>> rtl/deep_ctrl.sv
// Added by the designer: the plain strobed port.
`timescale 1ns/1ns
`default_nettype none
// Notes on behaviour
// RULE1 - latch mode clear: eeprom area reads return array bytes.
// RULE2 - master sets latch mode with program bit clear before loading.
// RULE3 - latch-mode writes land in one of 32 latches by low address.
// RULE4 - program bit set: latched bytes programmed into row of last write.
// RULE5 - master keeps row constant between programs; only five low bits vary.
// RULE6 - end of programming clears program and latch bits together.
// RULE7 - latches clear only at program end or latch fall; rewrites AND.
// RULE8 - latch contents are never readable.
// RULE9 - wait request: enter wait now if idle, else after cycle ends.
// RULE10 - halt request stops at once, abandoning programming.
// RULE11 - eeprom read in latch mode leaves data bus undriven.
// RULE12 - eeprom write outside latch mode ignored, no latch changes.
// RULE13 - reset aborts programming; controller returns cleanly to reset state.
// RULE14 - read-out protection blocks external reads and any rewrite.
// RULE15 - removing protection first erases program memory and whole eeprom.
// RULE16 - upper six control bits read zero, writes ignored.
// RULE17 - software clears latch mode only while program bit clear.
// RULE18 - program bit reads 1 for whole cycle, else 0.
// RULE19 - software clearing program bit aborts programming.
// RULE20 - cycle length timed internally.
// RULE21 - control/status at 0x0030, resets to zero.
// RULE22 - cycle duration is a parameterised counter raising completion.
// RULE23 - latch mode falling is one-cycle clear of latches and valids.
module deep_ctrl #(
  parameter logic [19:0] PROG_CYCLES = 20'(deep_pkg::PROG_CYCLES)
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic EXT_READ_I,
  input wire logic PROTECT_I,
  input wire logic UNPROTECT_REQ_I,
  input wire logic WAIT_REQ_I,
  input wire logic HALT_REQ_I,
  output logic [7:0] RDATA_O,
  output logic RDATA_OE_O,
  output logic PUMP_ON_O,
  output logic WAIT_O,
  output logic HALTED_O,
  output logic PROG_ERASE_O
);
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_PROG = 3'b010,
    ST_ERASE = 3'b100
  } deep_state_e;

  deep_state_e state_ff;
  deep_state_e nxt_state;
  logic latch_mode_flag_ff;
  logic program_flag_ff;
  logic [7:0] latch_ff [deep_pkg::LATCH_N];
  logic [deep_pkg::LATCH_N-1:0] valid_ff;
  logic [deep_pkg::ROW_W-1:0] row_ff;
  logic [19:0] cnt_ff;
  logic [7:0] array_ff [deep_pkg::EE_DEPTH];
  logic [deep_pkg::EE_ADDR_W-1:0] erase_ptr_ff;
  logic wait_ff;
  logic erase_done_ff;
  logic halt_s1_ff;
  logic halt_ff;
  logic wait_s1_ff;
  logic wait_s2_ff;
  logic unp_s1_ff;
  logic unp_s2_ff;
  logic [7:0] rdata_ff;
  logic rd_oe_ff;

  function automatic logic in_ee(input logic [15:0] a);
    in_ee = (a >= deep_pkg::EE_BASE) &&
            (a < deep_pkg::EE_BASE + 16'(deep_pkg::EE_DEPTH));
  endfunction

  // column picks the latch, row the cell row it will land in
  function automatic logic [deep_pkg::COL_W-1:0] col_of(
    input logic [deep_pkg::EE_ADDR_W-1:0] o
  );
    col_of = o[deep_pkg::COL_W-1:0];
  endfunction

  function automatic logic [deep_pkg::ROW_W-1:0] row_of(
    input logic [deep_pkg::EE_ADDR_W-1:0] o
  );
    row_of = o[deep_pkg::EE_ADDR_W-1:deep_pkg::COL_W];
  endfunction

  // ---------------------------------------------------------------
  // address decode and strobe qualification
  // ---------------------------------------------------------------
  logic ee_hit;
  logic csr_hit;
  logic csr_wr;
  logic ee_wr;
  logic prog_done;
  logic sw_abort;
  logic latch_fall;
  logic clr_latches;
  logic halt_abort;
  logic prog_go;
  logic erase_go;
  logic rd_csr;
  logic rd_array;
  logic [deep_pkg::EE_ADDR_W-1:0] ee_off;
  assign ee_hit = in_ee(ADDR_I);
  assign ee_off = deep_pkg::EE_ADDR_W'(ADDR_I - deep_pkg::EE_BASE);
  // RULE21 fixed address
  assign csr_hit = (ADDR_I == deep_pkg::CTRL_STATUS_ADDR);
  assign csr_wr = WR_I && csr_hit && !halt_ff;
  // RULE12 RULE14 writes gated
  assign ee_wr = WR_I && ee_hit && latch_mode_flag_ff && !program_flag_ff &&
                 !PROTECT_I && !halt_ff;
  // RULE20 RULE22 internal timer expiry
  assign prog_done = (state_ff == ST_PROG) && (cnt_ff == PROG_CYCLES - 20'd1);
  // RULE19 software abort
  assign sw_abort = (state_ff == ST_PROG) && csr_wr && !WDATA_I[deep_pkg::PROGRAM_BIT];
  // RULE10 halt abandons
  assign halt_abort = halt_ff && (state_ff == ST_PROG);
  // RULE17 latch clear only when idle
  assign latch_fall = csr_wr && latch_mode_flag_ff && !program_flag_ff && !prog_go &&
                      !WDATA_I[deep_pkg::LATCH_BIT];
  // RULE7 RULE23 clear sources
  assign clr_latches = prog_done || latch_fall;
  // RULE15 one sweep per removal request
  assign erase_go = (state_ff == ST_IDLE) && unp_s2_ff && PROTECT_I && !halt_ff &&
                    !erase_done_ff;
  // a write of the program bit alone must not count as a latch-mode fall
  assign prog_go = (state_ff == ST_IDLE) && !erase_go && csr_wr &&
                   WDATA_I[deep_pkg::PROGRAM_BIT] && latch_mode_flag_ff && !PROTECT_I &&
                   !wait_ff;
  assign rd_csr = RD_I && csr_hit;
  assign rd_array = RD_I && ee_hit && !latch_mode_flag_ff && !(PROTECT_I && EXT_READ_I);

  // ---------------------------------------------------------------
  // synchronisers for pin-level requests
  // ---------------------------------------------------------------
  // halt acts on the pump at once, so only the sync delay precedes it
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      halt_s1_ff <= 1'b0;
      halt_ff <= 1'b0;
    end else begin
      halt_s1_ff <= HALT_REQ_I;
      halt_ff <= halt_s1_ff;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wait_s1_ff <= 1'b0;
      wait_s2_ff <= 1'b0;
    end else begin
      wait_s1_ff <= WAIT_REQ_I;
      wait_s2_ff <= wait_s1_ff;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      unp_s1_ff <= 1'b0;
      unp_s2_ff <= 1'b0;
    end else begin
      unp_s1_ff <= UNPROTECT_REQ_I;
      unp_s2_ff <= unp_s1_ff;
    end
  end

  // ---------------------------------------------------------------
  // sequencer
  // ---------------------------------------------------------------
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE: begin
        // RULE15 erase before unprotect
        if (erase_go) begin
          nxt_state = ST_ERASE;
        end else if (prog_go) begin
          nxt_state = ST_PROG;
        end
      end
      ST_PROG: begin
        if (prog_done || sw_abort || halt_ff) begin
          nxt_state = ST_IDLE;
        end
      end
      ST_ERASE: begin
        if (erase_ptr_ff == deep_pkg::EE_ADDR_W'(deep_pkg::EE_DEPTH - 1)) begin
          nxt_state = ST_IDLE;
        end
      end
      default: nxt_state = ST_IDLE;
    endcase
  end

  // RULE13 reset returns to idle
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      state_ff <= ST_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  // ---------------------------------------------------------------
  // programming timer
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      cnt_ff <= 20'd0;
    end else if (state_ff == ST_PROG) begin
      cnt_ff <= cnt_ff + 20'd1;
    end else begin
      cnt_ff <= 20'd0;
    end
  end

  // ---------------------------------------------------------------
  // control/status bits
  // ---------------------------------------------------------------
  // RULE19 abort drops bit
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      program_flag_ff <= deep_pkg::CTRL_STATUS_RST[deep_pkg::PROGRAM_BIT];
    end else if (prog_done || sw_abort || halt_abort) begin
      program_flag_ff <= 1'b0;
    end else if (prog_go) begin
      // RULE18 high for whole cycle
      program_flag_ff <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      latch_mode_flag_ff <= deep_pkg::CTRL_STATUS_RST[deep_pkg::LATCH_BIT];
    end else if (prog_done) begin
      // RULE6 both cleared together
      latch_mode_flag_ff <= 1'b0;
    end else if (csr_wr && !program_flag_ff && !prog_go) begin
      // RULE17 ignored while programming
      latch_mode_flag_ff <= WDATA_I[deep_pkg::LATCH_BIT];
    end
  end

  // ---------------------------------------------------------------
  // data latches; no read path exists for them
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      valid_ff <= '0;
    end else if (clr_latches) begin
      valid_ff <= '0;
    end else if (ee_wr) begin
      valid_ff[col_of(ee_off)] <= 1'b1;
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      row_ff <= '0;
    end else if (ee_wr) begin
      // RULE4 row from last write
      row_ff <= row_of(ee_off);
    end
  end

  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      for (int i = 0; i < deep_pkg::LATCH_N; i++) begin
        latch_ff[i] <= deep_pkg::ERASED_BYTE;
      end
    end else if (clr_latches) begin
      for (int i = 0; i < deep_pkg::LATCH_N; i++) begin
        latch_ff[i] <= deep_pkg::ERASED_BYTE;
      end
    end else if (ee_wr) begin
      // RULE3 RULE7 store by column, AND over repeats
      latch_ff[col_of(ee_off)] <= latch_ff[col_of(ee_off)] & WDATA_I;
    end
  end

  // ---------------------------------------------------------------
  // cell array model: commit at timer expiry, erase sweep
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      erase_ptr_ff <= '0;
    end else if (state_ff == ST_ERASE) begin
      erase_ptr_ff <= erase_ptr_ff + deep_pkg::EE_ADDR_W'(1);
    end else begin
      erase_ptr_ff <= '0;
    end
  end

  // held until the request drops, so a long request erases only once
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      erase_done_ff <= 1'b0;
    end else if (!unp_s2_ff) begin
      erase_done_ff <= 1'b0;
    end else if (state_ff == ST_ERASE) begin
      erase_done_ff <= 1'b1;
    end
  end

  // no reset: cell contents are nonvolatile and an aborted row stays as it was
  always_ff @(posedge CORE_CLK_I) begin
    if (state_ff == ST_ERASE) begin
      array_ff[erase_ptr_ff] <= deep_pkg::ERASED_BYTE;
    end else if (prog_done) begin
      // RULE4 commit valid latches
      for (int i = 0; i < deep_pkg::LATCH_N; i++) begin
        if (valid_ff[i]) begin
          array_ff[{row_ff, deep_pkg::COL_W'(i)}] <= latch_ff[i];
        end
      end
    end
  end

  // ---------------------------------------------------------------
  // low power
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      wait_ff <= 1'b0;
    end else if (!wait_s2_ff) begin
      wait_ff <= 1'b0;
    end else if (state_ff == ST_IDLE && nxt_state == ST_IDLE) begin
      // RULE9 wait only once idle
      // never on the edge that starts a program
      wait_ff <= 1'b1;
    end
  end

  // ---------------------------------------------------------------
  // register read port
  // ---------------------------------------------------------------
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      rdata_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
    end else begin
      rdata_ff <= 8'h00;
      rd_oe_ff <= 1'b0;
      if (rd_csr) begin
        // RULE16 upper bits zero
        rdata_ff <= {6'h00, latch_mode_flag_ff, program_flag_ff};
        rd_oe_ff <= 1'b1;
      end else if (rd_array) begin
        // RULE1 RULE8 RULE11 RULE14 array only, never latches
        rdata_ff <= array_ff[ee_off];
        rd_oe_ff <= 1'b1;
      end
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign RDATA_O = rdata_ff;
  assign RDATA_OE_O = rd_oe_ff;
  // pump drops with the synced halt, a cycle before the state does
  assign PUMP_ON_O = (state_ff == ST_PROG) && !halt_ff;
  assign WAIT_O = wait_ff;
  assign HALTED_O = halt_ff;
  assign PROG_ERASE_O = (state_ff == ST_ERASE);
endmodule
`default_nettype wire

// >>> bench/deep_ctrl_chk.sv
`timescale 1ns/1ns
`default_nettype none
module deep_ctrl_chk #(
  parameter logic [19:0] PROG_CYCLES = 20'(deep_pkg::PROG_CYCLES)
) (
  input wire logic CORE_CLK_I,
  input wire logic RST_I,
  input wire logic [15:0] ADDR_I,
  input wire logic [7:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  input wire logic EXT_READ_I,
  input wire logic PROTECT_I,
  input wire logic UNPROTECT_REQ_I,
  input wire logic WAIT_REQ_I,
  input wire logic HALT_REQ_I,
  input wire logic [7:0] RDATA_O,
  input wire logic RDATA_OE_O,
  input wire logic PUMP_ON_O,
  input wire logic WAIT_O,
  input wire logic HALTED_O,
  input wire logic PROG_ERASE_O
);
  // ---------------------------------------------
  // pump-on length, one count of slack for edges
  // ---------------------------------------------
  logic [19:0] on_cnt_ff;
  always_ff @(posedge CORE_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      on_cnt_ff <= '0;
    end else begin
      on_cnt_ff <= PUMP_ON_O ? on_cnt_ff + 20'h1 : '0;
    end
  end
  default clocking cb @(posedge CORE_CLK_I); endclocking
  default disable iff (RST_I);
  a_oe_cause: assert property (RDATA_OE_O |-> $past(RD_I))
    else $error("data driven without read");
  a_quiet_bus: assert property (!RDATA_OE_O |-> RDATA_O == 8'h00)
    else $error("data bus not quiet");
  a_csr_read: assert property ($past(RD_I && ADDR_I == 16'h0030)
    |-> RDATA_OE_O && RDATA_O[7:2] == 6'h00) else $error("bad control read");
  a_prog_bit: assert property ($past(RD_I && ADDR_I == 16'h0030)
    |-> RDATA_O[0] == $past(PUMP_ON_O)) else $error("program bit wrong");
  a_prog_bound: assert property (on_cnt_ff <= PROG_CYCLES + 20'h1)
    else $error("programming too long");
  a_pump_start: assert property ($rose(PUMP_ON_O) |-> $past(WR_I &&
    ADDR_I == 16'h0030 && WDATA_I[0] && !PROTECT_I)) else $error("bad start");
  a_ext_block: assert property ($past(RD_I && EXT_READ_I && PROTECT_I
    && ADDR_I[15:7] == 9'h020) |-> !RDATA_OE_O) else $error("read not blocked");
  a_wait_idle: assert property (WAIT_O |-> !PUMP_ON_O)
    else $error("wait while programming");
  a_halt_idle: assert property (HALTED_O && $past(HALTED_O) |-> !PUMP_ON_O)
    else $error("halt did not stop");
  a_erase_cause: assert property ($rose(PROG_ERASE_O) |-> $past(PROTECT_I))
    else $error("erase without protect");
  a_erase_span: assert property ($rose(PROG_ERASE_O) |=> PROG_ERASE_O[*8])
    else $error("erase too short");
endmodule
bind deep_ctrl deep_ctrl_chk #(.PROG_CYCLES(PROG_CYCLES)) deep_ctrl_chk_inst (.*);
`default_nettype wire

// >>> bench/deep_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none
module deep_cpu_model (
  input wire logic clk_i,
  input wire logic [7:0] rdata_i,
  input wire logic oe_i,
  output logic [15:0] addr_o,
  output logic [7:0] wdata_o,
  output logic wr_o,
  output logic rd_o
);
  // ------------------------------------------
  // bus master, idle lines show inverted value
  // ------------------------------------------
  initial begin
    addr_o = 16'h0000;
    wdata_o = 8'h00;
    wr_o = 1'b0;
    rd_o = 1'b0;
  end
  task automatic wr_b(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    wdata_o <= d;
    wr_o <= 1'b1;
    @(posedge clk_i);
    wr_o <= 1'b0;
    addr_o <= ~a;
    wdata_o <= ~d;
  endtask
  task automatic rd_b(input logic [15:0] a, output logic oe, output logic [7:0] d);
    @(posedge clk_i);
    addr_o <= a;
    rd_o <= 1'b1;
    @(posedge clk_i);
    rd_o <= 1'b0;
    addr_o <= ~a;
    #1;
    oe = oe_i;
    d = rdata_i;
  endtask
endmodule
`default_nettype wire

// >>> bench/testbench.sv
`timescale 1ns/1ns
`default_nettype none
module testbench;
  logic clk, rst, ext, prot, unp, wreq, hreq, wr, rd, oe, pump, wt, hlt, ers;
  logic [15:0] addr;
  logic [7:0] wdata, rdata;
  int bad_count, n_tests;
  deep_ctrl #(.PROG_CYCLES(20'd20)) deep_ctrl_inst (.CORE_CLK_I(clk), .RST_I(rst),
    .ADDR_I(addr), .WDATA_I(wdata), .WR_I(wr), .RD_I(rd), .EXT_READ_I(ext),
    .PROTECT_I(prot), .UNPROTECT_REQ_I(unp), .WAIT_REQ_I(wreq), .HALT_REQ_I(hreq),
    .RDATA_O(rdata), .RDATA_OE_O(oe), .PUMP_ON_O(pump), .WAIT_O(wt),
    .HALTED_O(hlt), .PROG_ERASE_O(ers));
  deep_cpu_model deep_cpu_model_inst (.clk_i(clk), .rdata_i(rdata), .oe_i(oe),
    .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
  // ---------------------
  // access and compare
  // ---------------------
  task automatic w(input logic [15:0] a, input logic [7:0] d);
    deep_cpu_model_inst.wr_b(a, d);
  endtask
  task automatic rc(input logic [15:0] a, input logic e_oe, input logic [7:0] e_d);
    logic g_oe;
    logic [7:0] g_d;
    deep_cpu_model_inst.rd_b(a, g_oe, g_d);
    n_tests++;
    if (g_oe !== e_oe || g_d !== e_d) begin
      bad_count++;
      $display("[ERR] %0t read %h got %b/%h", $time, a, g_oe, g_d);
    end
  endtask
  task automatic cf(input logic g, input logic e);
    n_tests++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %0t flag %b exp %b", $time, g, e);
    end
  endtask
  task automatic results;
    if (bad_count == 0 && n_tests > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial begin
    #1000000;
    bad_count++;
    results;
  end
  initial begin
    {rst, ext, prot, unp, wreq, hreq} = 6'h20;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    rc(16'h0030, 1'b1, 8'h00);
    w(16'h0030, 8'hfc);
    rc(16'h0030, 1'b1, 8'h00);
    w(16'h0030, 8'h02);
    rc(16'h1005, 1'b0, 8'h00);
    w(16'h1005, 8'h5a);
    w(16'h1005, 8'hf0);
    w(16'h1006, 8'h33);
    w(16'h0030, 8'h03);
    rc(16'h0030, 1'b1, 8'h03);
    for (int i = 0; i < 60 && pump; i++) @(negedge clk);
    rc(16'h0030, 1'b1, 8'h00);
    rc(16'h1005, 1'b1, 8'h50);
    rc(16'h1006, 1'b1, 8'h33);
    w(16'h1005, 8'h00);
    rc(16'h1005, 1'b1, 8'h50);
    w(16'h0030, 8'h02);
    w(16'h1008, 8'h77);
    w(16'h0030, 8'h03);
    w(16'h0030, 8'h02);
    rc(16'h0030, 1'b1, 8'h02);
    w(16'h1009, 8'h44);
    w(16'h0030, 8'h03);
    @(posedge clk) hreq <= 1'b1;
    for (int i = 0; i < 20 && !hlt; i++) @(negedge clk);
    cf(hlt, 1'b1);
    cf(pump, 1'b0);
    rc(16'h0030, 1'b1, 8'h02);
    @(posedge clk) hreq <= 1'b0;
    for (int i = 0; i < 20 && hlt; i++) @(negedge clk);
    w(16'h0030, 8'h03);
    @(posedge clk) wreq <= 1'b1;
    repeat (6) @(negedge clk);
    cf(wt, 1'b0);
    for (int i = 0; i < 60 && !wt; i++) @(negedge clk);
    cf(pump, 1'b0);
    rc(16'h1009, 1'b1, 8'h44);
    @(posedge clk) wreq <= 1'b0;
    for (int i = 0; i < 20 && wt; i++) @(negedge clk);
    @(posedge clk) {prot, ext} <= 2'h3;
    rc(16'h1005, 1'b0, 8'h00);
    w(16'h0030, 8'h02);
    w(16'h0030, 8'h03);
    @(negedge clk) cf(pump, 1'b0);
    w(16'h0030, 8'h00);
    @(posedge clk) unp <= 1'b1;
    for (int i = 0; i < 20 && !ers; i++) @(negedge clk);
    cf(ers, 1'b1);
    for (int i = 0; i < 300 && ers; i++) @(negedge clk);
    @(posedge clk) {prot, ext, unp} <= 3'h0;
    rc(16'h1005, 1'b1, 8'hff);
    w(16'h0030, 8'h02);
    w(16'h1005, 8'h12);
    w(16'h0030, 8'h03);
    @(posedge clk) rst <= 1'b1;
    @(posedge clk) rst <= 1'b0;
    rc(16'h0030, 1'b1, 8'h00);
    cf(pump, 1'b0);
    results;
  end
endmodule
`default_nettype wire
